// ---- core/eht_edge_handshake.sv ----
/*
 Edge handshake engine for a 32-bit parallel port, plus its word FIFO.
 Assumes an Avalon-MM master on mclk and a peripheral whose strobe and
 data arrive asynchronously on pins.
*/
// Chosen here: the register addresses and the Avalon-MM interface to the registers.
// How it works
// [RULE1] Trailing mode: each side marks readiness with its strobe's trailing edge.
// [RULE2] Leading mode: each side marks readiness with its strobe's active-going edge.
// [RULE3] Long-pulse mode: the delay lengthens the ack pulse, never postpones it.
// [RULE4] Emulation of a classic interface chip: both strobes low, 500 ns pulses.
// [RULE5] Trailing mode: ack pulse lasts 225 to 275 ns, plus the delay.
// [RULE6] Trailing input with request latching: capture on request trailing edge.
// [RULE7] Trailing input without request latching: capture on our ack active edge.
// [RULE8] Peer may release its strobe no earlier than our ack goes inactive.
// [RULE9] Latched output: next word within 50 ns of request going inactive.
// [RULE10] Unlatched output: data valid 25 ns before ack, plus delay when leading.
// [RULE11] Trailing output latching defaults off; word holds to request trailing edge.
// [RULE12] Leading input: ack stays active 150 ns past request going inactive.
// [RULE13] Leading input with request latching: capture on request active edge.
// [RULE14] Leading latched output: word holds until request deasserts, then may change.
// [RULE15] Leading unlatched output: word may change after request active edge.
// [RULE16] Polarity of ack and request strobes is set by software.
// [RULE17] Latched input words are sampled at the request edge before the host reads.
// [RULE18] Programmable delay is a count of mclk cycles.
// [RULE19] Request strobe is synchronised and edge-detected before the FSM uses it.
`timescale 1ns/1ps
`include "eht_cfg.svh"

module eht_fifo #(
  parameter int WIDTH = 32,
  parameter int DEPTH = 16
) (
  input wire logic mclk,
  input wire logic sys_rst,
  input wire logic inValid,
  output logic inReady,
  input wire logic [WIDTH-1:0] inData,
  output logic outValid,
  input wire logic outReady,
  output logic [WIDTH-1:0] outData,
  output logic [$clog2(DEPTH):0] level
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wrPtr_q;
  logic [AW-1:0] rdPtr_q;
  logic [AW:0] cnt_q;
  logic push;
  logic pop;

  assign inReady = cnt_q != (AW+1)'(DEPTH);
  assign outValid = cnt_q != '0;
  assign outData = mem[rdPtr_q];
  assign level = cnt_q;
  assign push = inValid && inReady;
  assign pop = outValid && outReady;

  always_ff @(posedge mclk) begin
    if (push) begin
      mem[wrPtr_q] <= inData;
    end
  end

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      wrPtr_q <= '0;
      rdPtr_q <= '0;
    end else begin
      if (push) wrPtr_q <= wrPtr_q + AW'(1);
      if (pop) rdPtr_q <= rdPtr_q + AW'(1);
    end
  end

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      cnt_q <= '0;
    end else if (push && !pop) begin
      cnt_q <= cnt_q + (AW+1)'(1);
    end else if (pop && !push) begin
      cnt_q <= cnt_q - (AW+1)'(1);
    end
  end
endmodule : eht_fifo

module eht_edge_handshake
  import eht_pkg::*;
(
  input wire logic mclk,
  input wire logic sys_rst,
  input wire logic [3:0] avsAddress,
  input wire logic avsRead,
  input wire logic avsWrite,
  input wire logic [31:0] avsWritedata,
  output logic [31:0] avsReaddata,
  output logic avsWaitrequest,
  input wire logic peerStrobeIn,
  output logic readyStrobeOut,
  input wire logic [31:0] portDataIn,
  output logic [31:0] portDataOut,
  output logic portDataOe
);
  localparam logic [9:0] TRAIL_MIN = 10'(`EHT_CYC_CEIL(`EHT_T_TRAIL_MIN_NS));
  localparam logic [9:0] TRAIL_MAX = 10'(`EHT_CYC_FLOOR(`EHT_T_TRAIL_MAX_NS));
  localparam logic [9:0] LEAD_IN_W = 10'(`EHT_CYC_CEIL(`EHT_T_LEAD_IN_NS));
  localparam logic [9:0] LEAD_OUT_W = 10'(`EHT_CYC_CEIL(`EHT_T_LEAD_OUT_NS));
  localparam logic [9:0] LONG_W = 10'(`EHT_CYC_CEIL(`EHT_T_LONG_NS));
  localparam logic [9:0] REL_CYC = 10'(`EHT_CYC_CEIL(`EHT_T_RELEASE_NS));
  localparam logic [9:0] SETUP_CYC = 10'(`EHT_CYC_CEIL(`EHT_T_SETUP_NS));
  localparam logic [9:0] COMPAT_W = 10'(`EHT_CYC_CEIL(`EHT_T_COMPAT_NS));
  localparam int UPD_CYC = `EHT_CYC_FLOOR(`EHT_T_UPDATE_NS);

  ////////////////////////////////////////////////////////////////////
  eht_ctrl_t ctrl_q;
  logic [7:0] delay_q;
  eht_state_t state_q;
  logic [9:0] cnt_q;
  logic [9:0] relCnt_q;
  logic [9:0] ackLen_q;
  logic [9:0] doAge_q;
  logic ackAct_q;
  logic seen_q;
  logic loaded_q;
  logic rdAck_q;
  logic reqS1_q;
  logic reqS2_q;
  logic reqS3_q;
  logic [31:0] dataS1_q;
  logic [31:0] dataS2_q;
  logic [31:0] rdData_q;

  logic fifoInValid;
  logic fifoInReady;
  logic [31:0] fifoInData;
  logic fifoOutValid;
  logic fifoOutReady;
  logic [31:0] fifoOutData;
  logic [4:0] fifoLevel;

  logic ackLowEff;
  logic reqLowEff;
  logic reqAct;
  logic reqActPrev;
  logic reqRise;
  logic reqFall;
  logic leading;
  logic [9:0] delayExt;
  logic [9:0] widthTgt;
  logic [9:0] setupTgt;
  logic startOk;
  logic pushHs;
  logic busPush;
  logic busPop;
  logic loadWord;
  logic leadDone;
  logic wrData;

  ////////////////////////////////////////////////////////////////////
  // Strobe and data synchronisers
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      reqS1_q <= 1'b0;
      reqS2_q <= 1'b0;
      reqS3_q <= 1'b0;
    end else begin
      reqS1_q <= peerStrobeIn;
      reqS2_q <= reqS1_q;
      reqS3_q <= reqS2_q;
    end
  end

  always_ff @(posedge mclk) begin
    dataS1_q <= portDataIn;
    dataS2_q <= dataS1_q;
  end

  // Emulation forces both strobes active low in long-pulse mode
  assign ackLowEff = ctrl_q.ackLow || (ctrl_q.compat && ctrl_q.mode == EHT_LONG); // RULE4 RULE16
  assign reqLowEff = ctrl_q.reqLow || (ctrl_q.compat && ctrl_q.mode == EHT_LONG); // RULE4 RULE16
  assign reqAct = reqS2_q ^ reqLowEff;
  assign reqActPrev = reqS3_q ^ reqLowEff;
  assign reqRise = reqAct && !reqActPrev; // RULE19
  assign reqFall = !reqAct && reqActPrev; // RULE19
  assign leading = ctrl_q.mode != EHT_TRAIL;

  ////////////////////////////////////////////////////////////////////
  // Timing targets in mclk cycles
  assign delayExt = {2'b00, delay_q}; // RULE18

  always_comb begin
    unique case (ctrl_q.mode)
      EHT_TRAIL: widthTgt = TRAIL_MIN + delayExt; // RULE5
      EHT_LEAD: widthTgt = ctrl_q.dirOut ? LEAD_OUT_W : LEAD_IN_W;
      default: begin
        widthTgt = LONG_W + delayExt; // RULE3
        if (ctrl_q.compat && widthTgt < COMPAT_W) widthTgt = COMPAT_W; // RULE4
      end
    endcase
  end

  always_comb begin
    setupTgt = ctrl_q.dirOut ? SETUP_CYC : 10'h000; // RULE10
    if (ctrl_q.mode == EHT_LEAD) setupTgt = setupTgt + delayExt; // RULE10 RULE18
  end

  assign startOk = ctrl_q.enable && (ctrl_q.dirOut ? loaded_q : fifoInReady);
  assign leadDone = cnt_q >= widthTgt && seen_q && !reqAct && relCnt_q >= REL_CYC; // RULE12

  ////////////////////////////////////////////////////////////////////
  // Handshake state machine
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      state_q <= EHT_IDLE;
      cnt_q <= '0;
      ackAct_q <= 1'b0;
    end else begin
      unique case (state_q)
        EHT_IDLE: begin
          cnt_q <= '0;
          if (startOk) state_q <= EHT_SETUP;
        end
        EHT_SETUP: begin
          cnt_q <= cnt_q + 10'h001;
          if (cnt_q >= setupTgt) begin
            state_q <= EHT_ACKON;
            cnt_q <= 10'h001;
            ackAct_q <= 1'b1; // RULE1 RULE2
          end
        end
        EHT_ACKON: begin
          if (cnt_q != 10'h3FF) cnt_q <= cnt_q + 10'h001;
          if (!leading && cnt_q >= widthTgt) begin
            state_q <= EHT_WAITREQ; // RULE5
            ackAct_q <= 1'b0;
          end else if (leading && leadDone) begin
            state_q <= EHT_IDLE; // RULE12
            ackAct_q <= 1'b0;
          end
        end
        EHT_WAITREQ: begin
          if (reqFall) state_q <= EHT_IDLE; // RULE1 RULE8
        end
      endcase
    end
  end

  always_ff @(posedge mclk) begin
    if (sys_rst || state_q == EHT_IDLE) begin
      seen_q <= 1'b0;
    end else if (state_q == EHT_ACKON && reqRise) begin
      seen_q <= 1'b1; // RULE2
    end
  end

  always_ff @(posedge mclk) begin
    if (sys_rst || reqAct) begin
      relCnt_q <= '0;
    end else if (relCnt_q != 10'h3FF) begin
      relCnt_q <= relCnt_q + 10'h001;
    end
  end

  always_ff @(posedge mclk) begin
    if (sys_rst || !ackAct_q) begin
      ackLen_q <= 10'h001;
    end else if (ackLen_q != 10'h3FF) begin
      ackLen_q <= ackLen_q + 10'h001;
    end
  end

  assign readyStrobeOut = ackAct_q ^ ackLowEff; // RULE16

  ////////////////////////////////////////////////////////////////////
  // Input capture
  always_comb begin
    pushHs = 1'b0;
    if (!ctrl_q.dirOut) begin
      if (!ctrl_q.latchIn) begin
        pushHs = state_q == EHT_SETUP && cnt_q >= setupTgt; // RULE7
      end else if (!leading) begin
        pushHs = state_q == EHT_WAITREQ && reqFall; // RULE6 RULE17
      end else begin
        pushHs = state_q == EHT_ACKON && reqRise && !seen_q; // RULE13 RULE17
      end
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Output word
  assign loadWord = ctrl_q.dirOut && ctrl_q.enable && !loaded_q && fifoOutValid;

  always_ff @(posedge mclk) begin
    if (sys_rst || !ctrl_q.dirOut) begin
      loaded_q <= 1'b0;
    end else if (loadWord) begin
      loaded_q <= 1'b1;
    end else if (!leading && state_q == EHT_WAITREQ && reqFall) begin
      loaded_q <= 1'b0; // RULE9 RULE11
    end else if (leading && ctrl_q.latchOut && seen_q && reqFall) begin
      loaded_q <= 1'b0; // RULE9 RULE14
    end else if (leading && !ctrl_q.latchOut && state_q == EHT_ACKON && reqRise) begin
      loaded_q <= 1'b0; // RULE15
    end
  end

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      portDataOut <= '0;
      doAge_q <= '0;
    end else if (loadWord) begin
      portDataOut <= fifoOutData;
      doAge_q <= '0;
    end else if (doAge_q != 10'h3FF) begin
      doAge_q <= doAge_q + 10'h001;
    end
  end

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      portDataOe <= 1'b0;
    end else begin
      portDataOe <= ctrl_q.dirOut && ctrl_q.enable;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Word FIFO, shared by both directions
  assign fifoInValid = ctrl_q.dirOut ? busPush : pushHs;
  assign fifoInData = ctrl_q.dirOut ? avsWritedata : dataS2_q;
  assign fifoOutReady = ctrl_q.dirOut ? loadWord : busPop;

  eht_fifo #(.WIDTH(32), .DEPTH(16)) wordFifo (
    .mclk(mclk),
    .sys_rst(sys_rst),
    .inValid(fifoInValid),
    .inReady(fifoInReady),
    .inData(fifoInData),
    .outValid(fifoOutValid),
    .outReady(fifoOutReady),
    .outData(fifoOutData),
    .level(fifoLevel)
  );

  ////////////////////////////////////////////////////////////////////
  // Avalon-MM slave
  assign wrData = avsAddress == `EHT_OFS_DATA;
  assign avsWaitrequest = (avsRead && !rdAck_q)
      || (avsWrite && wrData && ctrl_q.dirOut && !fifoInReady);
  assign busPush = avsWrite && wrData && ctrl_q.dirOut;
  assign busPop = avsRead && rdAck_q && wrData && !ctrl_q.dirOut;
  assign avsReaddata = rdData_q;

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      rdAck_q <= 1'b0;
    end else begin
      rdAck_q <= avsRead && !rdAck_q;
    end
  end

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      rdData_q <= '0;
    end else if (avsRead && !rdAck_q) begin
      rdData_q <= '0;
      unique case (avsAddress)
        `EHT_OFS_CTRL: rdData_q[`EHT_CTRL_W-1:0] <= ctrl_q;
        `EHT_OFS_DELAY: rdData_q[7:0] <= delay_q;
        `EHT_OFS_DATA: rdData_q <= (!ctrl_q.dirOut && fifoOutValid) ? fifoOutData : '0;
        `EHT_OFS_STATUS: begin
          rdData_q[`EHT_STAT_LEVEL_LSB +: 5] <= fifoLevel;
          rdData_q[`EHT_STAT_EMPTY_BIT] <= !fifoOutValid;
          rdData_q[`EHT_STAT_FULL_BIT] <= !fifoInReady;
          rdData_q[`EHT_STAT_ACK_BIT] <= ackAct_q;
          rdData_q[`EHT_STAT_REQ_BIT] <= reqAct;
          rdData_q[`EHT_STAT_STATE_LSB +: 4] <= state_q;
        end
        default: rdData_q <= '0;
      endcase
    end
  end

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      ctrl_q <= `EHT_CTRL_RST; // RULE11
      delay_q <= `EHT_DELAY_RST;
    end else if (avsWrite && avsAddress == `EHT_OFS_CTRL) begin
      ctrl_q <= avsWritedata[`EHT_CTRL_W-1:0];
    end else if (avsWrite && avsAddress == `EHT_OFS_DELAY) begin
      delay_q <= avsWritedata[7:0]; // RULE18
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Checks
  a_trail_width: assert property ( // RULE5
    @(posedge mclk) disable iff (sys_rst)
    $fell(ackAct_q) && ctrl_q.mode == EHT_TRAIL |->
      $past(ackLen_q) >= TRAIL_MIN + delayExt && $past(ackLen_q) <= TRAIL_MAX + delayExt)
    else $error("trailing ack pulse width out of range");

  a_long_width: assert property ( // RULE3
    @(posedge mclk) disable iff (sys_rst)
    $fell(ackAct_q) && ctrl_q.mode == EHT_LONG |-> $past(ackLen_q) >= LONG_W + delayExt)
    else $error("long pulse ack too short");

  a_lead_release: assert property ( // RULE12
    @(posedge mclk) disable iff (sys_rst)
    $fell(ackAct_q) && leading && !ctrl_q.dirOut |-> $past(relCnt_q) >= REL_CYC)
    else $error("ack released too soon after request");

  a_out_setup: assert property ( // RULE10
    @(posedge mclk) disable iff (sys_rst)
    $rose(ackAct_q) && ctrl_q.dirOut && !ctrl_q.latchOut |-> doAge_q >= setupTgt)
    else $error("output data not set up before ack");

  a_trail_capture: assert property ( // RULE6
    @(posedge mclk) disable iff (sys_rst)
    state_q == EHT_WAITREQ && reqFall && !ctrl_q.dirOut && ctrl_q.latchIn |->
      fifoInValid && fifoInData == dataS2_q)
    else $error("trailing edge capture missed");

  a_lead_capture: assert property ( // RULE13
    @(posedge mclk) disable iff (sys_rst)
    state_q == EHT_ACKON && leading && reqRise && !seen_q && !ctrl_q.dirOut
      && ctrl_q.latchIn |-> fifoInValid ##1 seen_q)
    else $error("leading edge capture missed");

  a_ack_capture: assert property ( // RULE7
    @(posedge mclk) disable iff (sys_rst)
    $rose(ackAct_q) && !ctrl_q.dirOut && !ctrl_q.latchIn |-> $past(fifoInValid))
    else $error("capture at ack edge missed");

  a_out_update: assert property ( // RULE9
    @(posedge mclk) disable iff (sys_rst)
    !leading && state_q == EHT_WAITREQ && reqFall && ctrl_q.dirOut && ctrl_q.enable
      && fifoOutValid |=> !loaded_q ##[1:UPD_CYC] loaded_q)
    else $error("next output word late");

  a_ack_idle: assert property ( // RULE16
    @(posedge mclk) disable iff (sys_rst)
    state_q == EHT_IDLE |-> readyStrobeOut == ackLowEff && !ackAct_q)
    else $error("ack active while idle");
endmodule : eht_edge_handshake

// ---- shared/eht_cfg.svh ----
/*
 Offsets, reset values and timing figures of the edge handshake block.
 Assumes a 200 MHz mclk; included by bare name.
*/
`ifndef EHT_CFG_SVH
`define EHT_CFG_SVH

`define EHT_OFS_CTRL 4'h0
`define EHT_OFS_DELAY 4'h4
`define EHT_OFS_DATA 4'h8
`define EHT_OFS_STATUS 4'hC

`define EHT_CTRL_W 9
`define EHT_CTRL_RST 9'h010
`define EHT_DELAY_RST 8'h00

`define EHT_STAT_LEVEL_LSB 0
`define EHT_STAT_EMPTY_BIT 5
`define EHT_STAT_FULL_BIT 6
`define EHT_STAT_ACK_BIT 7
`define EHT_STAT_REQ_BIT 8
`define EHT_STAT_STATE_LSB 9

`define EHT_CLK_MHZ 200
`define EHT_T_TRAIL_MIN_NS 225
`define EHT_T_TRAIL_MAX_NS 275
`define EHT_T_LEAD_IN_NS 125
`define EHT_T_LEAD_OUT_NS 150
`define EHT_T_LONG_NS 125
`define EHT_T_RELEASE_NS 150
`define EHT_T_SETUP_NS 25
`define EHT_T_UPDATE_NS 50
`define EHT_T_COMPAT_NS 500

`define EHT_CYC_CEIL(ns) ((((ns) * `EHT_CLK_MHZ) + 999) / 1000)
`define EHT_CYC_FLOOR(ns) (((ns) * `EHT_CLK_MHZ) / 1000)

`endif

// ---- shared/eht_pkg.sv ----
/*
 Types of the edge handshake block: FSM states, modes, control word.
 Assumes nothing beyond a SystemVerilog compiler.
*/
package eht_pkg;

  typedef enum logic [3:0] {
    EHT_IDLE = 4'b0001,
    EHT_SETUP = 4'b0010,
    EHT_ACKON = 4'b0100,
    EHT_WAITREQ = 4'b1000
  } eht_state_t;

  typedef enum logic [1:0] {
    EHT_TRAIL = 2'h0,
    EHT_LEAD = 2'h1,
    EHT_LONG = 2'h2
  } eht_mode_t;

  typedef struct packed {
    logic latchOut;
    logic compat;
    logic reqLow;
    logic ackLow;
    logic latchIn;
    eht_mode_t mode;
    logic dirOut;
    logic enable;
  } eht_ctrl_t;

endpackage : eht_pkg

// ---- sim/edge_handshake_transfer_bench.sv ----
/*
 Self-checking bench of the edge handshake block.
 Assumes the peer model and the Avalon register map of eht_cfg.svh.
*/
`timescale 1ns/1ps
`include "eht_cfg.svh"
module edge_handshake_transfer_bench;
  logic mclk = 1'b0;
  logic sys_rst = 1'b1;
  logic [3:0] avsAddress = 4'h0;
  logic avsRead = 1'b0;
  logic avsWrite = 1'b0;
  logic [31:0] avsWritedata = 32'h0000_0000;
  logic ackLow = 1'b0;
  logic reqLow = 1'b0;
  logic [31:0] avsReaddata, portDataIn, portDataOut;
  logic avsWaitrequest, peerStrobeIn, readyStrobeOut, portDataOe;
  int n_fail = 0;
  int cmp_count = 0;

  initial begin
    forever #2.5 mclk = ~mclk;
  end

  eht_edge_handshake dut (.mclk(mclk), .sys_rst(sys_rst), .avsAddress(avsAddress),
    .avsRead(avsRead), .avsWrite(avsWrite), .avsWritedata(avsWritedata),
    .avsReaddata(avsReaddata), .avsWaitrequest(avsWaitrequest),
    .peerStrobeIn(peerStrobeIn), .readyStrobeOut(readyStrobeOut),
    .portDataIn(portDataIn), .portDataOut(portDataOut), .portDataOe(portDataOe));

  eht_peer_model peer (.mclk(mclk), .ackLow(ackLow), .reqLow(reqLow),
    .readyStrobeOut(readyStrobeOut), .portDataOut(portDataOut),
    .portDataOe(portDataOe), .peerStrobeIn(peerStrobeIn), .portDataIn(portDataIn));
  //////////////////////////////////////////////////////////////
  task automatic results();
    $display("Compares %0d, errors %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : results

  task automatic cmpVal(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      n_fail++;
      $display("Error %0t: got %h expected %h", $time, got, exp);
    end
  endtask : cmpVal

  task automatic cmpMin(input int got, input int lo);
    cmp_count++;
    if (got < lo) begin
      n_fail++;
      $display("Error %0t: count %0d below %0d", $time, got, lo);
    end
  endtask : cmpMin

  task automatic busAcc(input logic wr, input logic [3:0] a, input logic [31:0] d,
                        output logic [31:0] q);
    int t;
    t = 0;
    avsAddress <= a;
    avsWritedata <= d;
    avsWrite <= wr;
    avsRead <= ~wr;
    do begin
      @(posedge mclk);
      t++;
    end while (avsWaitrequest !== 1'b0 && t < 1000);
    q = avsReaddata;
    if (avsWaitrequest !== 1'b0) begin
      n_fail++;
      $display("Error %0t: bus access timed out", $time);
    end
    avsWrite <= 1'b0;
    avsRead <= 1'b0;
    @(posedge mclk);
  endtask : busAcc

  task automatic busWr(input logic [3:0] a, input logic [31:0] d);
    logic [31:0] q;
    busAcc(1'b1, a, d, q);
  endtask : busWr

  task automatic ackWidth(output int n);
    int t;
    t = 0;
    n = 0;
    do begin
      @(negedge mclk);
      t++;
    end while ((readyStrobeOut ^ ackLow) !== 1'b1 && t < 2000);
    do begin
      @(negedge mclk);
      n++;
    end while ((readyStrobeOut ^ ackLow) === 1'b1 && n < 2000);
    @(posedge mclk);
  endtask : ackWidth
  //////////////////////////////////////////////////////////////
  task automatic resetValues();
    logic [31:0] d;
    busAcc(1'b0, `EHT_OFS_CTRL, 32'h0000_0000, d);
    cmpVal(d, 32'h0000_0010);
    busAcc(1'b0, `EHT_OFS_DELAY, 32'h0000_0000, d);
    cmpVal(d, 32'h0000_0000);
    busAcc(1'b0, `EHT_OFS_STATUS, 32'h0000_0000, d);
    cmpVal(d & 32'h0000_1FFF, 32'h0000_0220);
    busAcc(1'b0, 4'h2, 32'h0000_0000, d);
    cmpVal(d, 32'h0000_0000);
    cmpVal({30'h0000_0000, readyStrobeOut, portDataOe}, 32'h0000_0000);
  endtask : resetValues

  task automatic trailInput();
    int n;
    logic [31:0] d;
    busWr(`EHT_OFS_DELAY, 32'h0000_0003);
    busWr(`EHT_OFS_CTRL, 32'h0000_0011);
    for (int i = 0; i < 3; i++) begin
      ackWidth(n);
      cmpVal(32'(n), 32'h0000_0030);
      // Disable before the last handshake ends, so no new one starts
      if (i == 2) busWr(`EHT_OFS_CTRL, 32'h0000_0010);
      peer.trailIn(32'h5A3C_0F00 + 32'(i), 20);
    end
    for (int i = 0; i < 3; i++) begin
      busAcc(1'b0, `EHT_OFS_DATA, 32'h0000_0000, d);
      cmpVal(d, 32'h5A3C_0F00 + 32'(i));
    end
  endtask : trailInput

  task automatic trailUnlatched();
    int n;
    logic [31:0] d;
    peer.present(32'h9610_0C3A);
    busWr(`EHT_OFS_CTRL, 32'h0000_0001);
    ackWidth(n);
    cmpVal(32'(n), 32'h0000_0030);
    busWr(`EHT_OFS_CTRL, 32'h0000_0000);
    peer.trailIn(32'h0000_0000, 20);
    busAcc(1'b0, `EHT_OFS_DATA, 32'h0000_0000, d);
    cmpVal(d, 32'h9610_0C3A);
  endtask : trailUnlatched

  task automatic outputDrain();
    logic [31:0] d, a, r;
    busWr(`EHT_OFS_CTRL, 32'h0000_0002);
    for (int i = 0; i < 16; i++) busWr(`EHT_OFS_DATA, 32'hC0DE_0000 + 32'(i));
    busAcc(1'b0, `EHT_OFS_STATUS, 32'h0000_0000, d);
    cmpVal(d & 32'h0000_007F, 32'h0000_0050);
    busWr(`EHT_OFS_CTRL, 32'h0000_0003);
    for (int i = 0; i < 16; i++) begin
      peer.trailOut((i % 4 == 3) ? 40 : 0, a, r);
      cmpVal(a, 32'hC0DE_0000 + 32'(i));
      cmpVal(r, 32'hC0DE_0000 + 32'(i));
    end
    cmpVal({31'h0000_0000, portDataOe}, 32'h0000_0001);
    busAcc(1'b0, `EHT_OFS_STATUS, 32'h0000_0000, d);
    cmpVal(d & 32'h0000_0060, 32'h0000_0020);
  endtask : outputDrain

  task automatic longPulse();
    int n, g;
    logic [31:0] d;
    busWr(`EHT_OFS_DELAY, 32'h0000_0064);
    busWr(`EHT_OFS_CTRL, 32'h0000_0019);
    // Disable during the pulse so the engine rests in idle afterwards
    fork
      ackWidth(n);
      busWr(`EHT_OFS_CTRL, 32'h0000_0018);
      peer.leadIn(32'h7E11_0000, 20, g);
    join
    cmpVal(32'(n), 32'h0000_007D);
    busAcc(1'b0, `EHT_OFS_DATA, 32'h0000_0000, d);
    cmpVal(d, 32'h7E11_0000);
    busWr(`EHT_OFS_CTRL, 32'h0000_00F8);
    ackLow <= 1'b1;
    reqLow <= 1'b1;
    repeat (4) @(posedge mclk);
    @(negedge mclk);
    cmpVal({31'h0000_0000, readyStrobeOut}, 32'h0000_0001);
    @(posedge mclk);
    busWr(`EHT_OFS_DELAY, 32'h0000_0000);
    busWr(`EHT_OFS_CTRL, 32'h0000_00F9);
    fork
      ackWidth(n);
      busWr(`EHT_OFS_CTRL, 32'h0000_00F8);
      peer.leadIn(32'h7E11_0001, 20, g);
    join
    cmpVal(32'(n), 32'h0000_0064);
    cmpMin(g, 30);
    busAcc(1'b0, `EHT_OFS_DATA, 32'h0000_0000, d);
    cmpVal(d, 32'h7E11_0001);
  endtask : longPulse

  task automatic leadInput();
    int g;
    logic [31:0] d;
    busWr(`EHT_OFS_CTRL, 32'h0000_0074);
    busWr(`EHT_OFS_CTRL, 32'h0000_0075);
    for (int i = 0; i < 2; i++) begin
      peer.leadIn(32'h3C96_0000 + 32'(i), 20, g);
      cmpMin(g, 30);
    end
    for (int i = 0; i < 2; i++) begin
      busAcc(1'b0, `EHT_OFS_DATA, 32'h0000_0000, d);
      cmpVal(d, 32'h3C96_0000 + 32'(i));
    end
  endtask : leadInput
  //////////////////////////////////////////////////////////////
  initial begin
    #200_000;
    n_fail++;
    results();
  end

  initial begin
    repeat (4) @(posedge mclk);
    sys_rst <= 1'b0;
    @(posedge mclk);
    resetValues();
    trailInput();
    trailUnlatched();
    outputDrain();
    longPulse();
    leadInput();
    results();
  end
endmodule : edge_handshake_transfer_bench

// ---- sim/eht_peer_model.sv ----
/*
 Peripheral model: drives the request strobe and the input data pins.
 Assumes its tasks are called just after a rising mclk edge.
*/
`timescale 1ns/1ps
module eht_peer_model (
  input wire logic mclk,
  input wire logic ackLow,
  input wire logic reqLow,
  input wire logic readyStrobeOut,
  input wire logic [31:0] portDataOut,
  input wire logic portDataOe,
  output logic peerStrobeIn,
  output logic [31:0] portDataIn
);
  logic reqAct = 1'b0;
  logic [31:0] drv = 32'h0000_0000;
  logic ackAct;
  assign ackAct = readyStrobeOut ^ ackLow;
  assign peerStrobeIn = reqAct ^ reqLow;
  // Released pins carry the inverse of the last word
  assign portDataIn = portDataOe ? portDataOut : drv;
  //////////////////////////////////////////////////////////////
  task automatic waitAck(input logic lvl);
    int t;
    t = 0;
    do begin
      @(negedge mclk);
      t++;
    end while (ackAct !== lvl && t < 4000);
  endtask : waitAck

  // Puts a word on the pins ahead of an unlatched capture
  task automatic present(input logic [31:0] w);
    drv <= w;
  endtask : present

  task automatic trailIn(input logic [31:0] w, input int width);
    waitAck(1'b0);
    @(posedge mclk);
    reqAct <= 1'b1;
    drv <= ~w;
    repeat (width / 2) @(posedge mclk);
    drv <= w;
    repeat (width / 2) @(posedge mclk);
    waitAck(1'b0);
    @(posedge mclk);
    reqAct <= 1'b0;
    repeat (4) @(posedge mclk);
    drv <= ~w;
  endtask : trailIn

  task automatic leadIn(input logic [31:0] w, input int width, output int gap);
    waitAck(1'b1);
    @(posedge mclk);
    drv <= w;
    @(posedge mclk);
    reqAct <= 1'b1;
    repeat (4) @(posedge mclk);
    drv <= ~w;
    repeat (width - 4) @(posedge mclk);
    reqAct <= 1'b0;
    gap = 0;
    do begin
      @(negedge mclk);
      gap++;
    end while (ackAct === 1'b1 && gap < 4000);
    @(posedge mclk);
  endtask : leadIn

  task automatic trailOut(input int stall, output logic [31:0] atAck,
                          output logic [31:0] atRel);
    waitAck(1'b1);
    atAck = portDataOut;
    waitAck(1'b0);
    @(posedge mclk);
    repeat (stall) @(posedge mclk);
    reqAct <= 1'b1;
    repeat (16) @(posedge mclk);
    reqAct <= 1'b0;
    @(negedge mclk);
    atRel = portDataOut;
    @(posedge mclk);
  endtask : trailOut
endmodule : eht_peer_model
